//--- logic/edge_detect.sv
// Purpose: register input levels and flag their edges
// Assumes: inputs synchronous to clk_sys
// Notes: edges show in the same cycle the level is registered
`timescale 1ns/1ns
`include "home_defs.svh"

module edge_detect (
  input wire logic clk_sys, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic [`SNS_W-1:0] raw, // home, fwd limit, rev limit, z
  sense_if.src sns // registered levels and edges
);

  logic [`SNS_W-1:0] level_ff;
  logic [`SNS_W-1:0] prev_ff;
  logic [`SNS_W-1:0] nxt_level;
  logic [`SNS_W-1:0] nxt_prev;

  always_comb begin
    nxt_level = raw;
    nxt_prev = level_ff;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      level_ff <= `SNS_RST;
      prev_ff <= `SNS_RST;
    end else begin
      level_ff <= nxt_level;
      prev_ff <= nxt_prev;
    end
  end

  assign sns.level = level_ff;
  assign sns.rise = level_ff & ~prev_ff;
  assign sns.fall = ~level_ff & prev_ff;

endmodule : edge_detect

//--- logic/home_defs.svh
// Purpose: shared constants of the homing sequencer
// Assumes: included by its bare name
// Notes: definitions only
`ifndef HOME_DEFS_SVH
`define HOME_DEFS_SVH

// width of the method selection field
`define METHOD_W 4
// highest method code this block runs; 10 is refused
`define METHOD_LAST 4'h9

// sense vector layout
`define SNS_W 4
`define SNS_HOME 0
`define SNS_FWD 1
`define SNS_REV 2
`define SNS_Z 3

// reset values
`define DONE_RST 1'b0
`define FAIL_RST 1'b0
`define TOWARD_RST 1'b1
`define SPEED_HI_RST 1'b0
`define SNS_RST 4'h0

`endif

//--- logic/home_pkg.sv
// Purpose: types of the homing sequencer
// Assumes: nothing
// Notes: constants live in home_defs.svh
package home_pkg;

  // which input marks the slow-down point
  typedef enum logic [1:0] {
    SRC_HOME,
    SRC_LIMIT,
    SRC_ZPULSE
  } decel_src_e;

  // decoded method
  typedef struct packed {
    logic valid;
    logic start_rev;
    decel_src_e src;
    logic ref_z;
  } method_s;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SEARCH_HI,
    ST_BACK_HI,
    ST_BACK_LO,
    ST_SEEK_Z,
    ST_DONE,
    ST_FAIL
  } home_state_e;

endpackage : home_pkg

//--- logic/home_return_sequencer.sv
// Purpose: homing sequencer for a position-controlled servo axis
// Assumes: all inputs synchronous to clk_sys; motion profile handled outside
// Notes: odd methods mirror the even ones with the direction turned round
`timescale 1ns/1ns
`include "home_defs.svh"

module home_return_sequencer (
  input wire logic clk_sys, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic start_req, // one-cycle request to start homing
  input wire logic abort_req, // one-cycle request to stop homing
  input wire logic [`METHOD_W-1:0] homing_method_select, // method code
  input wire logic home_switch, // home switch level
  input wire logic forward_travel_limit, // forward limit, high blocks forward
  input wire logic reverse_travel_limit, // reverse limit, high blocks reverse
  input wire logic encoder_z, // encoder index pulse
  output logic drive_fwd, // command forward motion
  output logic drive_rev, // command reverse motion
  output logic speed_high, // high homing speed in ST_SEARCH_HI and ST_BACK_HI, else low except after a start refused while at high speed
  output logic homing_busy, // sequence in progress
  output logic homing_done_output, // homing completed
  output logic homing_fail, // homing failed or method refused
  output logic home_capture // one-cycle pulse when home is taken
);

  sense_if sns ();

  // sense vector order must match the bit positions in home_defs.svh
  logic [`SNS_W-1:0] raw;
  assign raw = {encoder_z, reverse_travel_limit, forward_travel_limit, home_switch};

  edge_detect u_edge (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .raw(raw),
    .sns(sns)
  );

  home_pkg::home_state_e state_ff;
  home_pkg::home_state_e nxt_state;
  home_pkg::method_s method_ff;
  home_pkg::method_s nxt_method;
  home_pkg::method_s dec;
  logic toward_ff;
  logic nxt_toward;
  logic speed_hi_ff;
  logic nxt_speed_hi;
  logic done_ff;
  logic nxt_done;
  logic fail_ff;
  logic nxt_fail;
  logic capture_ff;
  logic nxt_capture;

  // decode the requested method
  always_comb begin
    dec.valid = (homing_method_select <= `METHOD_LAST);
    dec.start_rev = homing_method_select[0];
    dec.ref_z = 1'b0;
    unique case (homing_method_select[3:1])
      3'h0: begin
        dec.src = home_pkg::SRC_HOME;
      end
      3'h1: begin
        dec.src = home_pkg::SRC_HOME;
        dec.ref_z = 1'b1;
      end
      3'h2: begin
        dec.src = home_pkg::SRC_LIMIT;
      end
      3'h3: begin
        dec.src = home_pkg::SRC_LIMIT;
        dec.ref_z = 1'b1;
      end
      3'h4: begin
        dec.src = home_pkg::SRC_ZPULSE;
        dec.ref_z = 1'b1;
      end
      default: begin
        dec.src = home_pkg::SRC_ZPULSE;
        dec.ref_z = 1'b1;
      end
    endcase
  end

  // limits seen relative to the starting direction of the latched method (new_lim_d_lvl: of the requested method)
  logic lim_d_lvl;
  logic lim_d_rise;
  logic lim_d_fall;
  logic lim_o_lvl;
  logic new_lim_d_lvl;
  logic phys_fwd;
  logic lim_cur_lvl;
  logic moving;

  always_comb begin
    if (method_ff.start_rev) begin
      lim_d_lvl = sns.level[`SNS_REV];
      lim_d_rise = sns.rise[`SNS_REV];
      lim_d_fall = sns.fall[`SNS_REV];
      lim_o_lvl = sns.level[`SNS_FWD];
    end else begin
      lim_d_lvl = sns.level[`SNS_FWD];
      lim_d_rise = sns.rise[`SNS_FWD];
      lim_d_fall = sns.fall[`SNS_FWD];
      lim_o_lvl = sns.level[`SNS_REV];
    end
    new_lim_d_lvl = dec.start_rev ? sns.level[`SNS_REV] : sns.level[`SNS_FWD];
    phys_fwd = toward_ff ^ method_ff.start_rev;
    lim_cur_lvl = phys_fwd ? sns.level[`SNS_FWD] : sns.level[`SNS_REV];
    moving = (state_ff == home_pkg::ST_SEARCH_HI) || (state_ff == home_pkg::ST_BACK_HI) ||
             (state_ff == home_pkg::ST_BACK_LO) || (state_ff == home_pkg::ST_SEEK_Z);
  end

  // slow-down edges of the latched method; new_dec_lvl is the level for the requested method
  logic dec_rise;
  logic dec_fall;
  logic new_dec_lvl;

  always_comb begin
    unique case (method_ff.src)
      home_pkg::SRC_HOME: begin
        dec_rise = sns.rise[`SNS_HOME];
        dec_fall = sns.fall[`SNS_HOME];
      end
      home_pkg::SRC_LIMIT: begin
        dec_rise = lim_d_rise;
        dec_fall = lim_d_fall;
      end
      default: begin
        dec_rise = sns.rise[`SNS_Z];
        dec_fall = 1'b0;
      end
    endcase
    unique case (dec.src)
      home_pkg::SRC_HOME: new_dec_lvl = sns.level[`SNS_HOME];
      home_pkg::SRC_LIMIT: new_dec_lvl = new_lim_d_lvl;
      default: new_dec_lvl = 1'b0;
    endcase
  end

  // sequence
  always_comb begin
    nxt_state = state_ff;
    nxt_method = method_ff;
    nxt_toward = toward_ff;
    nxt_speed_hi = speed_hi_ff;
    nxt_done = done_ff;
    nxt_fail = fail_ff;
    nxt_capture = 1'b0;
    // abort wins over start; a start mid-sequence restarts the search
    if (abort_req) begin
      nxt_state = home_pkg::ST_IDLE;
      nxt_done = 1'b0;
      nxt_speed_hi = 1'b0;
    end else if (start_req) begin
      nxt_method = dec;
      nxt_done = 1'b0;
      nxt_fail = 1'b0;
      if (!dec.valid) begin
        nxt_state = home_pkg::ST_FAIL;
        nxt_fail = 1'b1;
      end else if (new_dec_lvl) begin
        // already at the slow-down point: back off slowly
        nxt_state = home_pkg::ST_BACK_LO;
        nxt_toward = 1'b0;
        nxt_speed_hi = 1'b0;
      end else begin
        nxt_state = home_pkg::ST_SEARCH_HI;
        nxt_toward = 1'b1;
        nxt_speed_hi = 1'b1;
      end
    end else begin
      unique case (state_ff)
        home_pkg::ST_IDLE: begin
        end
        home_pkg::ST_SEARCH_HI: begin
          if (dec_rise) begin
            if (method_ff.ref_z && method_ff.src != home_pkg::SRC_ZPULSE) begin
              // home switch methods keep direction, limit methods turn round
              nxt_state = home_pkg::ST_SEEK_Z;
              nxt_toward = (method_ff.src == home_pkg::SRC_HOME);
              nxt_speed_hi = 1'b0;
            end else begin
              nxt_state = home_pkg::ST_DONE;
              nxt_done = 1'b1;
              nxt_capture = 1'b1;
              nxt_speed_hi = 1'b0;
            end
          end else if (lim_d_lvl) begin
            if (method_ff.src == home_pkg::SRC_HOME) begin
              nxt_state = home_pkg::ST_BACK_HI;
              nxt_toward = 1'b0;
            end else begin
              nxt_state = home_pkg::ST_FAIL;
              nxt_fail = 1'b1;
              nxt_speed_hi = 1'b0;
            end
          end
        end
        home_pkg::ST_BACK_HI: begin
          if (!method_ff.ref_z && sns.rise[`SNS_HOME]) begin
            nxt_state = home_pkg::ST_DONE;
            nxt_done = 1'b1;
            nxt_capture = 1'b1;
            nxt_speed_hi = 1'b0;
          end else if (method_ff.ref_z && sns.fall[`SNS_HOME]) begin
            nxt_state = home_pkg::ST_SEEK_Z;
            nxt_toward = 1'b1;
            nxt_speed_hi = 1'b0;
          end else if (lim_o_lvl) begin
            nxt_state = home_pkg::ST_FAIL;
            nxt_fail = 1'b1;
            nxt_speed_hi = 1'b0;
          end
        end
        home_pkg::ST_BACK_LO: begin
          if (dec_fall) begin
            if (method_ff.ref_z) begin
              // switch methods seek the index in the start direction,
              // limit methods seek it heading away from the limit
              nxt_state = home_pkg::ST_SEEK_Z;
              nxt_toward = (method_ff.src == home_pkg::SRC_HOME);
            end else begin
              nxt_state = home_pkg::ST_DONE;
              nxt_done = 1'b1;
              nxt_capture = 1'b1;
            end
          end else if (lim_o_lvl) begin
            nxt_state = home_pkg::ST_FAIL;
            nxt_fail = 1'b1;
          end
        end
        home_pkg::ST_SEEK_Z: begin
          if (sns.rise[`SNS_Z]) begin
            nxt_state = home_pkg::ST_DONE;
            nxt_done = 1'b1;
            nxt_capture = 1'b1;
          end else if (lim_cur_lvl) begin
            nxt_state = home_pkg::ST_FAIL;
            nxt_fail = 1'b1;
          end
        end
        home_pkg::ST_DONE: begin
        end
        home_pkg::ST_FAIL: begin
          // fail stands until the next start; abort leaves it set
          nxt_done = 1'b0;
        end
      endcase
    end
  end

  // reset leaves the axis idle with done, fail, speed and capture low and toward_ff high
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= home_pkg::ST_IDLE;
      method_ff <= '0;
      toward_ff <= `TOWARD_RST;
      speed_hi_ff <= `SPEED_HI_RST;
      done_ff <= `DONE_RST;
      fail_ff <= `FAIL_RST;
      capture_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      method_ff <= nxt_method;
      toward_ff <= nxt_toward;
      speed_hi_ff <= nxt_speed_hi;
      done_ff <= nxt_done;
      fail_ff <= nxt_fail;
      capture_ff <= nxt_capture;
    end
  end

  // raw limit levels gate motion at once, without the sense register delay
  assign drive_fwd = moving && phys_fwd && !forward_travel_limit;
  assign drive_rev = moving && !phys_fwd && !reverse_travel_limit;
  assign speed_high = speed_hi_ff;
  // busy covers the moving states only; done and fail are idle states
  assign homing_busy = moving;
  assign homing_done_output = done_ff;
  assign homing_fail = fail_ff;
  assign home_capture = capture_ff;

endmodule : home_return_sequencer

//--- logic/sense_if.sv
// Purpose: registered levels and edges of the homing inputs
// Assumes: one driver, one reader
// Notes: bit layout as in home_defs.svh
`timescale 1ns/1ns
`include "home_defs.svh"

interface sense_if;
  logic [`SNS_W-1:0] level;
  logic [`SNS_W-1:0] rise;
  logic [`SNS_W-1:0] fall;

  modport src (output level, output rise, output fall);
  modport dst (input level, input rise, input fall);
endinterface : sense_if

//--- testbench/axis_model.sv
// Purpose: switch, limits and index from a simulated axis position
// Assumes: one count per div cycles of drive
// Notes: limits at +-200, switch on 40..60, index every 16 counts
`timescale 1ns/1ns
module axis_model (
  input wire logic clk_sys, // clock
  input wire logic drive_fwd, // fwd drive
  input wire logic drive_rev, // rev drive
  output logic home_switch, // switch
  output logic forward_travel_limit, // fwd limit
  output logic reverse_travel_limit, // rev limit
  output logic encoder_z, // index
  output int age_home, // cycles since change
  output int age_fl, // cycles since change
  output int age_rl, // cycles since change
  output int age_z // cycles since change
);
  int pos = 0;
  int div = 1;
  int tick = 0;
  logic n;
  initial {home_switch, forward_travel_limit, reverse_travel_limit, encoder_z} = 4'h0;
  task automatic place(input int p, input int d);
    pos = p;
    div = d;
  endtask : place
  always @(posedge clk_sys) begin
    #1;
    tick++;
    if (tick >= div) begin
      tick = 0;
      if (drive_fwd) pos++;
      else if (drive_rev) pos--;
    end
    n = pos >= 40 && pos <= 60;
    age_home = (n != home_switch) ? 0 : age_home + 1;
    home_switch = n;
    n = pos >= 200;
    age_fl = (n != forward_travel_limit) ? 0 : age_fl + 1;
    forward_travel_limit = n;
    n = pos <= -200;
    age_rl = (n != reverse_travel_limit) ? 0 : age_rl + 1;
    reverse_travel_limit = n;
    n = (pos & 15) == 0;
    age_z = (n != encoder_z) ? 0 : age_z + 1;
    encoder_z = n;
  end
endmodule : axis_model

//--- testbench/home_return_sequencer_tb.sv
// Purpose: self-checking bench for home_return_sequencer
// Assumes: axis_model stands for switch, limits and index
// Notes: every method from fixed and random start points
`timescale 1ns/1ns
`include "home_defs.svh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin error_cnt++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module home_return_sequencer_tb;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic start_req = 1'b0;
  logic abort_req = 1'b0;
  logic [`METHOD_W-1:0] sel = 4'h0;
  logic hsw, fl, rl, ez, dfw, drv, spd, busy, done, fail, cap;
  int age_home, age_fl, age_rl, age_z;
  int error_cnt = 0;
  int samples_checked = 0;
  int cycles = 0;
  initial forever #2 clk_sys = ~clk_sys;
  home_return_sequencer i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .start_req(start_req),
    .abort_req(abort_req), .homing_method_select(sel), .home_switch(hsw),
    .forward_travel_limit(fl), .reverse_travel_limit(rl), .encoder_z(ez),
    .drive_fwd(dfw), .drive_rev(drv), .speed_high(spd), .homing_busy(busy),
    .homing_done_output(done), .homing_fail(fail), .home_capture(cap));
  axis_model i_axis (.clk_sys(clk_sys), .drive_fwd(dfw), .drive_rev(drv),
    .home_switch(hsw), .forward_travel_limit(fl), .reverse_travel_limit(rl),
    .encoder_z(ez), .age_home(age_home), .age_fl(age_fl), .age_rl(age_rl), .age_z(age_z));
  task automatic step(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask : step
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : wrap_up
  // {low speed not wanted, fwd, rev} one cycle after start
  function automatic logic [2:0] exp_drive(input logic [3:0] m, input logic h, f, r);
    logic act;
    act = (m < 4'h4) ? h : (m < 4'h8) ? (m[0] ? r : f) : 1'b0;
    return (m[0] ^ act) ? {!act, 1'b0, !r} : {!act, !f, 1'b0};
  endfunction : exp_drive
  function automatic int ref_age(input logic [3:0] m);
    if (m >= 4'h8 || m[1]) return age_z;
    if (m < 4'h4) return age_home;
    return m[0] ? age_rl : age_fl;
  endfunction : ref_age
  task automatic pulse_start(input logic [3:0] m);
    sel = m;
    start_req = 1'b1;
    step(1);
    start_req = 1'b0;
  endtask : pulse_start
  task automatic run_one(input logic [3:0] m, input int p, input int d);
    logic [2:0] e;
    int k;
    i_axis.place(p, d);
    step(4);
    e = exp_drive(m, hsw, fl, rl);
    pulse_start(m);
    step(1);
    `CHK({dfw, drv}, e[1:0])
    `CHK(done, 1'b0)
    if (m < 4'h8) `CHK(spd, e[2])
    k = 0;
    while (cap !== 1'b1 && fail !== 1'b1 && k < 4000) begin
      step(1);
      k++;
    end
    `CHK({cap, done, fail}, 3'h6)
    `CHK(ref_age(m) <= 4, 1'b1)
    $display("test method %0d from %0d took %0d cycles", m, p, k);
  endtask : run_one
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 100000) begin
      error_cnt++;
      wrap_up();
    end
  end
  initial begin
    void'($urandom(4022));
    step(16);
    rst_n = 1'b1;
    step(4);
    for (int m = 0; m < 10; m++) begin
      run_one(m[3:0], 0, 1);
      run_one(m[3:0], 50, 2);
      run_one(m[3:0], 100, 1);
      if (m >= 4 && m < 8) run_one(m[3:0], m[0] ? -200 : 200, 1);
      run_one(m[3:0], int'($urandom_range(300)) - 150, int'($urandom_range(2, 1)));
    end
    i_axis.place(-100, 1);
    step(4);
    pulse_start(4'h0);
    step(6);
    abort_req = 1'b1;
    step(1);
    abort_req = 1'b0;
    `CHK({busy, done, dfw}, 3'h0)
    $display("test abort done");
    for (int m = 10; m < 16; m++) begin
      pulse_start(m[3:0]);
      `CHK({fail, busy}, 2'h2)
      step(1);
    end
    $display("test refused methods done");
    wrap_up();
  end
endmodule : home_return_sequencer_tb
bind home_return_sequencer home_seq_monitor i_mon (.clk_sys(clk_sys), .rst_n(rst_n),
  .start_req(start_req), .abort_req(abort_req), .homing_method_select(homing_method_select),
  .forward_travel_limit(forward_travel_limit), .reverse_travel_limit(reverse_travel_limit),
  .drive_fwd(drive_fwd), .drive_rev(drive_rev), .homing_busy(homing_busy),
  .homing_done_output(homing_done_output), .homing_fail(homing_fail),
  .home_capture(home_capture));

//--- testbench/home_seq_monitor.sv
// Purpose: port checker for home_return_sequencer
// Assumes: bound to the top module
// Notes: one clock domain
`timescale 1ns/1ns
`include "home_defs.svh"
module home_seq_monitor (
  input wire logic clk_sys, // clock
  input wire logic rst_n, // reset
  input wire logic start_req, // start
  input wire logic abort_req, // abort
  input wire logic [`METHOD_W-1:0] homing_method_select, // method
  input wire logic forward_travel_limit, // fwd limit
  input wire logic reverse_travel_limit, // rev limit
  input wire logic drive_fwd, // fwd drive
  input wire logic drive_rev, // rev drive
  input wire logic homing_busy, // busy
  input wire logic homing_done_output, // done
  input wire logic homing_fail, // fail
  input wire logic home_capture // capture
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  wire logic go = start_req && !abort_req;
  property p_fwd_block; forward_travel_limit |-> !drive_fwd; endproperty
  a_fwd_block: assert property (p_fwd_block) else $error("fwd drive at limit");
  property p_rev_block; reverse_travel_limit |-> !drive_rev; endproperty
  a_rev_block: assert property (p_rev_block) else $error("rev drive at limit");
  property p_done_cap; $rose(homing_done_output) |-> home_capture; endproperty
  a_done_cap: assert property (p_done_cap) else $error("done without capture");
  property p_cap; home_capture |-> homing_done_output ##1 !home_capture; endproperty
  a_cap: assert property (p_cap) else $error("capture pulse bad");
  property p_start_clr; go |=> !homing_done_output; endproperty
  a_start_clr: assert property (p_start_clr) else $error("done kept at start");
  property p_abort; abort_req |=> !homing_done_output && !homing_busy; endproperty
  a_abort: assert property (p_abort) else $error("abort ignored");
  property p_refuse;
    go && homing_method_select > `METHOD_LAST |=> homing_fail && !homing_busy;
  endproperty
  a_refuse: assert property (p_refuse) else $error("bad method run");
  property p_m8; go && homing_method_select == 4'h8 |=> homing_busy && !drive_rev; endproperty
  a_m8: assert property (p_m8) else $error("method 8 not forward");
  property p_m9; go && homing_method_select == 4'h9 |=> homing_busy && !drive_fwd; endproperty
  a_m9: assert property (p_m9) else $error("method 9 not reverse");
  property p_done_idle; homing_done_output |-> !homing_busy && !homing_fail; endproperty
  a_done_idle: assert property (p_done_idle) else $error("done while busy");
endmodule : home_seq_monitor
